// ---- counter_array_capture_compare.sv ----
// counter array: shared 16-bit time base, five compare/capture modules,
// watchdog on the last module, registers on an apb slave.
// assumes a 10 MHz ref_clk, async active-low rst_n, async module pins.
//
// Notes on behaviour
// - either capture edge enable set puts the module in capture mode.
// - a valid pin edge copies the counter into the compare register.
// - interrupt requested when module flag and its enable are set.
// - compare enable plus match enable gives a 16-bit software timer.
// - timer compares the counter each count; a match raises the flag.
// - pwm output low below active duty byte, high at or above it.
// - active duty byte reloads from compare high byte at low wrap.
// - pwm runs only with both pwm enable and compare enable set.
// - only module 4 is a watchdog; otherwise it works as any module.
// - with watchdog on, a module 4 match issues an internal reset.
// - the watchdog reset is internal and drives no external pin.
// - clearing watchdog enable before a match prevents the reset.
// - all modules share one counter; software should not rewrite it.
// - positive, negative or both enables capture rise, fall or any.
// - toggle enable makes a match invert the module pin.
// - watchdog enable bit turns the module 4 watchdog on and off.
`timescale 1ns/100ps
`default_nettype none

module counter_array_capture_compare #(
  parameter int NUM_MODULES = counter_array_pkg::NUM_MODULES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_MODULES-1:0] ioPinIn,
  output logic [NUM_MODULES-1:0] ioPinOut,
  output logic [NUM_MODULES-1:0] ioPinOe,
  output logic eventIrq,
  output logic watchdogReset
);

  localparam int WDOG = counter_array_pkg::WATCHDOG_MODULE;

  //////////////////////////////////////////////////////////////////////
  // state of the array outside the module units and the pin synchroniser
  typedef struct packed {
    logic [15:0] count;
    logic run;
    logic wdEnable;
    logic [NUM_MODULES-1:0] flag;
    logic [NUM_MODULES-1:0][7:0] mode;
    logic [NUM_MODULES-1:0][15:0] compare;
    logic ack;
    logic [31:0] rdata;
    logic err;
    logic wdReset;
  } state_type;

  localparam state_type RESET_STATE = '{
    count: counter_array_pkg::COUNT_RESET,
    run: counter_array_pkg::RUN_RESET,
    wdEnable: counter_array_pkg::WATCHDOG_RESET,
    flag: '0,
    mode: {NUM_MODULES{counter_array_pkg::MODE_RESET}},
    compare: {NUM_MODULES{counter_array_pkg::COMPARE_RESET}},
    ack: 1'b0,
    rdata: 32'h00000000,
    err: 1'b0,
    wdReset: 1'b0
  };

  state_type s;
  state_type next_s;

  logic [NUM_MODULES-1:0] pinSync;
  logic [NUM_MODULES-1:0] captureEv;
  logic [NUM_MODULES-1:0] matchEv;
  logic [NUM_MODULES-1:0] eventEnable;
  logic [NUM_MODULES-1:0] flagClear;
  logic access;
  logic write;
  logic mapped;
  logic modeHit;
  logic cmpHit;
  logic [2:0] modeSlot;
  logic [2:0] cmpSlot;
  logic [31:0] readData;

  //////////////////////////////////////////////////////////////////////
  // address helpers: is the address one word of a module bank, and
  // which module does it pick
  function automatic logic inBank(input logic [7:0] addr,
                                  input logic [7:0] base);
    logic [7:0] diff;
    diff = addr - base;
    return (addr >= base) && (diff[1:0] == 2'b00) &&
           (diff[7:2] < 6'(NUM_MODULES));
  endfunction : inBank

  function automatic logic [2:0] slotOf(input logic [7:0] addr,
                                        input logic [7:0] base);
    logic [7:0] diff;
    diff = addr - base;
    return diff[4:2];
  endfunction : slotOf

  //////////////////////////////////////////////////////////////////////
  // pin synchroniser and the module units
  counter_array_sync #(.WIDTH(NUM_MODULES)) pinSyncer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .rawIn(ioPinIn),
    .syncOut(pinSync)
  );

  for (genvar g = 0; g < NUM_MODULES; g++) begin : unitGen
    // every unit sees the one shared time base
    counter_array_module_unit unit (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .tick(s.run),
      .count(s.count),
      .mode(s.mode[g]),
      .compare(s.compare[g]),
      .pinSync(pinSync[g]),
      .captureEvent(captureEv[g]),
      .matchEvent(matchEv[g]),
      .pinOut(ioPinOut[g]),
      .pinOe(ioPinOe[g])
    );
    assign eventEnable[g] = s.mode[g][counter_array_pkg::EVENT_IE_BIT];
  end

  //////////////////////////////////////////////////////////////////////
  // apb decode; one wait state so read data comes from a flop
  assign access = psel & penable;
  assign write = access & s.ack & pwrite & mapped;
  assign modeHit = inBank(paddr, counter_array_pkg::MODE_BASE);
  assign cmpHit = inBank(paddr, counter_array_pkg::COMPARE_BASE);
  assign modeSlot = slotOf(paddr, counter_array_pkg::MODE_BASE);
  assign cmpSlot = slotOf(paddr, counter_array_pkg::COMPARE_BASE);
  assign mapped = modeHit | cmpHit |
    (paddr == counter_array_pkg::CTRL_OFFSET) |
    (paddr == counter_array_pkg::FLAG_OFFSET) |
    (paddr == counter_array_pkg::COUNT_OFFSET);

  // flags are write-one-to-clear
  assign flagClear = (write && paddr == counter_array_pkg::FLAG_OFFSET) ?
    pwdata[NUM_MODULES-1:0] : '0;

  // read mux; unused and reserved bits read as zero
  always_comb begin
    readData = 32'h00000000;
    if (paddr == counter_array_pkg::CTRL_OFFSET) begin
      readData[counter_array_pkg::RUN_BIT] = s.run;
      readData[counter_array_pkg::WATCHDOG_ENABLE_BIT] = s.wdEnable;
    end else if (paddr == counter_array_pkg::FLAG_OFFSET) begin
      readData[NUM_MODULES-1:0] = s.flag;
    end else if (paddr == counter_array_pkg::COUNT_OFFSET) begin
      readData[15:0] = s.count;
    end else if (modeHit) begin
      readData[7:0] = s.mode[modeSlot];
    end else if (cmpHit) begin
      readData[15:0] = s.compare[cmpSlot];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_s = s;
    // free-running shared time base
    if (s.run) begin
      next_s.count = s.count + 16'h0001;
    end
    // capture copies both counter bytes into the module register
    for (int i = 0; i < NUM_MODULES; i++) begin
      if (captureEv[i]) begin
        next_s.compare[i] = s.count;
      end
    end
    // a new event beats a clear in the same cycle
    next_s.flag = (s.flag & ~flagClear) | captureEv | matchEv;
    // watchdog fires only while enabled; module 4 is
    // otherwise an ordinary module
    next_s.wdReset = s.wdEnable & matchEv[WDOG];
    // apb handshake
    next_s.ack = access & ~s.ack;
    next_s.err = 1'b0;
    if (access && !s.ack) begin
      next_s.rdata = readData;
      next_s.err = ~mapped;
    end
    // software writes win over the counter step and over a capture
    if (write) begin
      if (paddr == counter_array_pkg::CTRL_OFFSET) begin
        next_s.run = pwdata[counter_array_pkg::RUN_BIT];
        next_s.wdEnable =
          pwdata[counter_array_pkg::WATCHDOG_ENABLE_BIT];
      end
      if (paddr == counter_array_pkg::COUNT_OFFSET) begin
        next_s.count = pwdata[15:0];
      end
      if (modeHit) begin
        next_s.mode[modeSlot] = pwdata[7:0] & counter_array_pkg::MODE_MASK;
      end
      if (cmpHit) begin
        next_s.compare[cmpSlot] = pwdata[15:0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= RESET_STATE;
    end else begin
      s <= next_s;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs
  assign prdata = s.rdata;
  assign pready = s.ack;
  assign pslverr = s.ack & s.err;
  assign eventIrq = |(s.flag & eventEnable);
  // internal reset only; no external reset pin is driven from here
  assign watchdogReset = s.wdReset;

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence apbWait;
    psel && penable && !pready;
  endsequence

  sequence apbDone;
    psel && penable && pready;
  endsequence

  apb_wait_a: assert property (apbWait |=> apbDone)
    else $error("apb access not answered after one wait state");

  capture_load_a: assert property (
    captureEv[0] && !write |=> s.compare[0] == $past(s.count))
    else $error("capture did not copy the counter");

  capture_sel_a: assert property (
    s.mode[0][counter_array_pkg::POS_CAPTURE_BIT] &&
    $past(pinSync[0]) == 1'b0 && pinSync[0] && $stable(s.mode[0])
    |-> captureEv[0])
    else $error("rising edge missed in capture mode");

  timer_match_a: assert property (
    s.run && s.mode[0][counter_array_pkg::COMPARE_ENABLE_BIT] &&
    s.mode[0][counter_array_pkg::MATCH_ENABLE_BIT] &&
    s.count == s.compare[0] |=> s.flag[0])
    else $error("timer match did not raise the flag");

  irq_path_a: assert property (
    matchEv[0] && eventEnable[0] && !write |=> eventIrq)
    else $error("enabled event did not request an interrupt");

  flag_hold_a: assert property (
    s.flag[0] && !flagClear[0] |=> s.flag[0])
    else $error("event flag dropped without a clear");

  wdog_fire_a: assert property (
    s.wdEnable && matchEv[WDOG] |=> watchdogReset ##1 !watchdogReset)
    else $error("watchdog match did not pulse the reset");

  wdog_off_a: assert property (
    !s.wdEnable |=> !watchdogReset)
    else $error("reset issued with watchdog disabled");

  wdog_plain_a: assert property (
    matchEv[WDOG] && !s.wdEnable |=> s.flag[WDOG] && !watchdogReset)
    else $error("module 4 not usable as an ordinary module");

  count_step_a: assert property (
    s.run && !(write && paddr == counter_array_pkg::COUNT_OFFSET)
    |=> s.count == $past(s.count) + 16'h0001)
    else $error("time base did not step");

  //////////////////////////////////////////////////////////////////////
  // register bus, write paths and time base checks

  // a refused access answers with an error and empty read data
  apb_err_a: assert property (
    access && !s.ack && !mapped |=> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");

  apb_ok_a: assert property (access && !s.ack && mapped |=> !pslverr)
    else $error("mapped access flagged as an error");

  // ready only ever answers an access in progress
  apb_idle_a: assert property (!access |=> !pready)
    else $error("ready raised without an access");

  flag_clear_a: assert property (
    write && paddr == counter_array_pkg::FLAG_OFFSET && pwdata[0] &&
    !captureEv[0] && !matchEv[0] |=> !s.flag[0])
    else $error("event flag not cleared by software");

  mode_write_a: assert property (
    write && modeHit |=> s.mode[$past(modeSlot)] ==
    ($past(pwdata[7:0]) & counter_array_pkg::MODE_MASK))
    else $error("mode write lost or reserved bit kept");

  cmp_write_a: assert property (
    write && cmpHit
    |=> s.compare[$past(cmpSlot)] == $past(pwdata[15:0]))
    else $error("compare write lost");

  ctrl_write_a: assert property (
    write && paddr == counter_array_pkg::CTRL_OFFSET |=>
    s.wdEnable == $past(pwdata[counter_array_pkg::WATCHDOG_ENABLE_BIT]))
    else $error("watchdog enable write lost");

  // a stopped time base holds its value
  count_hold_a: assert property (
    !s.run && !(write && paddr == counter_array_pkg::COUNT_OFFSET)
    |=> $stable(s.count))
    else $error("stopped time base moved");

  count_load_a: assert property (
    write && paddr == counter_array_pkg::COUNT_OFFSET
    |=> s.count == $past(pwdata[15:0]))
    else $error("time base write lost");

  // a timer match on another module must not reach the watchdog reset
  wdog_only4_a: assert property (
    matchEv[1] && !matchEv[WDOG] |=> !watchdogReset)
    else $error("watchdog reset from a module other than 4");

  fall_capture_a: assert property (
    s.mode[1][counter_array_pkg::NEG_CAPTURE_BIT] &&
    $past(pinSync[1]) && !pinSync[1] |-> captureEv[1])
    else $error("falling edge missed in capture mode");

endmodule : counter_array_capture_compare
`default_nettype wire

// ---- counter_array_capture_compare_tb_top.sv ----
// bench of the counter array: apb tasks and register-level tests of
// capture, timer, toggle, pwm and watchdog behaviour.
// assumes the pin model file is compiled before this one.
`timescale 1ns/100ps
`default_nettype none

module counter_array_capture_compare_tb_top;
  localparam logic [7:0] CTRL = counter_array_pkg::CTRL_OFFSET;
  localparam logic [7:0] FLAG = counter_array_pkg::FLAG_OFFSET;
  localparam logic [7:0] CNT = counter_array_pkg::COUNT_OFFSET;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [4:0] want = 5'h00;
  logic [4:0] slow = 5'h0a;
  logic [4:0] ioPinIn;
  logic [4:0] ioPinOut;
  logic [4:0] ioPinOe;
  logic eventIrq;
  logic watchdogReset;
  int mismatches = 0;
  int n_checks = 0;
  int wdPulses = 0;

  counter_array_capture_compare uut (.ref_clk(ref_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ioPinIn(ioPinIn), .ioPinOut(ioPinOut),
    .ioPinOe(ioPinOe), .eventIrq(eventIrq),
    .watchdogReset(watchdogReset));

  counter_array_pin_model pins (.ref_clk(ref_clk), .want(want),
    .slow(slow), .pinOut(ioPinOut), .pinOe(ioPinOe), .pinIn(ioPinIn));

  // 10 MHz clock
  always #50 ref_clk = ~ref_clk;

  // count internal reset pulses; they never reach any pin
  always @(posedge ref_clk) begin
    if (watchdogReset === 1'b1) wdPulses <= wdPulses + 1;
  end

  ////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [7:0] modeA(input int m);
    return counter_array_pkg::MODE_BASE + 8'(4 * m);
  endfunction : modeA

  function automatic logic [7:0] cmpA(input int m);
    return counter_array_pkg::COMPARE_BASE + 8'(4 * m);
  endfunction : cmpA

  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one apb transfer; waits for pready with a bounded count
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("apb ready", {31'h0, pready}, 32'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask : rd

  // count high cycles of pin 2 over one full low-byte period
  task automatic duty(input logic [7:0] hb, input int expHigh);
    int hi;
    wr(cmpA(2), {16'h0, hb, 8'h00});
    repeat (600) @(posedge ref_clk);
    hi = 0;
    repeat (256) begin
      @(posedge ref_clk);
      if (ioPinOut[2] === 1'b1) hi++;
    end
    chk("pwm high count", 32'(hi), 32'(expHigh));
  endtask : duty

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin : main
    logic [31:0] r;
    logic e;
    logic [31:0] cap;
    logic pos;
    logic neg;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    apb(1'b0, 8'h10, 32'h0, r, e);
    chk("unmapped data", r, 32'h0);
    chk("unmapped error", {31'h0, e}, 32'h1);
    rd(CTRL, r);
    chk("ctrl reset", r, 32'h0);
    // capture: rise, fall or both per module, counter stopped
    for (int m = 0; m < 5; m++) begin
      pos = (m % 3) != 1;
      neg = (m % 3) != 0;
      rd(modeA(m), r);
      chk("mode reset", r, 32'h0);
      wr(modeA(m), {26'h0, pos, neg, 4'h1});
      wr(CNT, 32'h1000 + m);
      @(posedge ref_clk) want[m] <= 1'b1;
      repeat (10) @(posedge ref_clk);
      cap = pos ? 32'h1000 + m : 32'h0;
      rd(cmpA(m), r);
      chk("capture rise", r, cap);
      rd(FLAG, r);
      chk("flag rise", r, 32'(pos) << m);
      chk("irq rise", {31'h0, eventIrq}, {31'h0, pos});
      wr(FLAG, 32'h1f);
      wr(CNT, 32'h2000 + m);
      @(posedge ref_clk) want[m] <= 1'b0;
      repeat (10) @(posedge ref_clk);
      if (neg) cap = 32'h2000 + m;
      rd(cmpA(m), r);
      chk("capture fall", r, cap);
      rd(FLAG, r);
      chk("flag fall", r, 32'(neg) << m);
      wr(FLAG, 32'h1f);
    end
    // let the clearing edge settle before looking at the request
    @(posedge ref_clk);
    chk("irq cleared", {31'h0, eventIrq}, 32'h0);
    // software timer with toggle on module 1, interrupt masked first
    wr(modeA(1), 32'h4c);
    wr(cmpA(1), 32'h0030);
    wr(CNT, 32'h0);
    wr(CTRL, 32'h01);
    repeat (100) @(posedge ref_clk);
    rd(FLAG, r);
    chk("timer flag", r, 32'h2);
    chk("toggle pin", {31'h0, ioPinOut[1]}, 32'h1);
    chk("toggle oe", {31'h0, ioPinOe[1]}, 32'h1);
    chk("irq masked", {31'h0, eventIrq}, 32'h0);
    wr(modeA(1), 32'h4d);
    @(posedge ref_clk);
    chk("irq enabled", {31'h0, eventIrq}, 32'h1);
    repeat (50) @(posedge ref_clk);
    rd(FLAG, r);
    chk("flag held", r, 32'h2);
    wr(FLAG, 32'h1f);
    wr(modeA(1), 32'h0);
    // pwm on module 2 at duty boundaries
    wr(modeA(2), 32'h42);
    duty(8'h40, 192);
    duty(8'h00, 256);
    duty(8'hff, 1);
    chk("pwm oe", {31'h0, ioPinOe[2]}, 32'h1);
    // bit 7 is reserved and must read back as zero
    wr(modeA(2), 32'h82);
    rd(modeA(2), r);
    chk("mode mask", r, 32'h02);
    chk("pwm off oe", {31'h0, ioPinOe[2]}, 32'h0);
    // watchdog on module 4
    wr(cmpA(4), 32'h0100);
    wr(modeA(4), 32'h48);
    wr(CNT, 32'h00e0);
    wr(CTRL, 32'h41);
    repeat (100) @(posedge ref_clk);
    chk("wd reset", 32'(wdPulses), 32'h1);
    for (int i = 0; i < 5; i++) begin
      rd(CNT, r);
      wr(cmpA(4), {16'h0, r[15:0] + 16'h0080});
      repeat (40) @(posedge ref_clk);
    end
    chk("wd held off", 32'(wdPulses), 32'h1);
    wr(CTRL, 32'h01);
    wr(FLAG, 32'h1f);
    repeat (200) @(posedge ref_clk);
    chk("wd disabled", 32'(wdPulses), 32'h1);
    rd(FLAG, r);
    chk("module 4 timer", r, 32'h10);
    report_and_stop();
  end

  // hang guard: the tests need well under 10000 cycles
  initial begin : guard
    repeat (40000) @(posedge ref_clk);
    mismatches++;
    report_and_stop();
  end
endmodule : counter_array_capture_compare_tb_top
`default_nettype wire

// ---- counter_array_module_unit.sv ----
// one compare/capture module: edge capture, match, toggle and pwm.
// assumes a synchronised pin and a mode word held by the array.
`timescale 1ns/100ps
`default_nettype none

module counter_array_module_unit (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic [15:0] count,
  input wire logic [7:0] mode,
  input wire logic [15:0] compare,
  input wire logic pinSync,
  output logic captureEvent,
  output logic matchEvent,
  output logic pinOut,
  output logic pinOe
);

  typedef struct packed {
    logic pinPrev;
    logic pinLevel;
    logic [7:0] duty;
  } state_type;

  state_type s;
  state_type next_s;
  logic compareEnable;
  logic pwmActive;
  logic pwmHigh;
  logic toggleEnable;

  //////////////////////////////////////////////////////////////////////
  // mode decode
  assign compareEnable = mode[counter_array_pkg::COMPARE_ENABLE_BIT];
  assign toggleEnable = mode[counter_array_pkg::TOGGLE_BIT];
  assign pwmActive = mode[counter_array_pkg::PWM_BIT] & compareEnable;
  assign pwmHigh = count[7:0] >= s.duty;

  // edge select: rising, falling or both
  assign captureEvent =
    (mode[counter_array_pkg::POS_CAPTURE_BIT] & pinSync & ~s.pinPrev) |
    (mode[counter_array_pkg::NEG_CAPTURE_BIT] & ~pinSync & s.pinPrev);

  // a match counts only on a counter step, so a stopped counter
  // cannot fire the same match again and again
  assign matchEvent = tick & compareEnable &
    mode[counter_array_pkg::MATCH_ENABLE_BIT] & (count == compare);

  assign pinOe = compareEnable & (toggleEnable |
    mode[counter_array_pkg::PWM_BIT]);
  assign pinOut = s.pinLevel;

  //////////////////////////////////////////////////////////////////////
  // pin level and active duty byte
  always_comb begin
    next_s = s;
    next_s.pinPrev = pinSync;
    if (pwmActive) begin
      next_s.pinLevel = pwmHigh;
      if (tick && count[7:0] == counter_array_pkg::LOW_BYTE_TOP) begin
        next_s.duty = compare[15:8];
      end
    end else if (matchEvent && toggleEnable) begin
      next_s.pinLevel = ~s.pinLevel;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{pinPrev: 1'b0, pinLevel: 1'b0,
             duty: counter_array_pkg::DUTY_RESET};
    end else begin
      s <= next_s;
    end
  end

  //////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  pwm_level_a: assert property (
    pwmActive |=> pinOut == $past(pwmHigh))
    else $error("pwm level does not follow duty compare");

  duty_reload_a: assert property (
    pwmActive && tick && count[7:0] == 8'hff
    |=> s.duty == $past(compare[15:8]))
    else $error("duty byte not reloaded at low byte wrap");

  pwm_gate_a: assert property (
    mode[counter_array_pkg::PWM_BIT] && !compareEnable
    |=> pinOut == $past(pinOut))
    else $error("pwm ran without compare enable");

  toggle_a: assert property (
    matchEvent && toggleEnable && !pwmActive |=> pinOut != $past(pinOut))
    else $error("match did not toggle the pin");

  fall_only_a: assert property (
    !mode[counter_array_pkg::POS_CAPTURE_BIT] && pinSync && !s.pinPrev
    |-> !captureEvent)
    else $error("rising edge captured without positive enable");

endmodule : counter_array_module_unit
`default_nettype wire

// ---- counter_array_pin_model.sv ----
// far-side model of the five module pins: a source that drives each
// pin while the array does not, promptly or a few cycles late.
// assumes the bench sets want and slow after rising clock edges.
`timescale 1ns/100ps
`default_nettype none

module counter_array_pin_model #(
  parameter int N = 5
) (
  input wire logic ref_clk,
  input wire logic [N-1:0] want,
  input wire logic [N-1:0] slow,
  input wire logic [N-1:0] pinOut,
  input wire logic [N-1:0] pinOe,
  output logic [N-1:0] pinIn
);
  logic [N-1:0] late1 = '0;
  logic [N-1:0] late2 = '0;
  logic [N-1:0] late3 = '0;
  logic [N-1:0] drive;

  ////////////////////////////////////////////////////////////////////
  // slow pins lag three cycles, to show capture does not rely on timing
  always @(posedge ref_clk) begin
    late1 <= want;
    late2 <= late1;
    late3 <= late2;
  end

  // pin level: the array wins while it drives, else our edge source
  assign drive = (slow & late3) | (~slow & want);
  assign pinIn = (pinOe & pinOut) | (~pinOe & drive);
endmodule : counter_array_pin_model
`default_nettype wire

// ---- counter_array_pkg.sv ----
// package of the counter array: register offsets, field positions,
// reset values and sizes shared by the array and its module units.
// assumes an apb slave with byte addresses and 32-bit data.
package counter_array_pkg;

  // sizes
  localparam int NUM_MODULES = 5;
  localparam int WATCHDOG_MODULE = 4;
  localparam int ADDR_WIDTH = 8;

  //////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] FLAG_OFFSET = 8'h04;
  localparam logic [7:0] COUNT_OFFSET = 8'h08;
  localparam logic [7:0] MODE_BASE = 8'h20;
  localparam logic [7:0] COMPARE_BASE = 8'h40;

  //////////////////////////////////////////////////////////////////////
  // control register fields
  localparam int RUN_BIT = 0;
  localparam int WATCHDOG_ENABLE_BIT = 6;

  // module mode register fields
  localparam int COMPARE_ENABLE_BIT = 6;
  localparam int POS_CAPTURE_BIT = 5;
  localparam int NEG_CAPTURE_BIT = 4;
  localparam int MATCH_ENABLE_BIT = 3;
  localparam int TOGGLE_BIT = 2;
  localparam int PWM_BIT = 1;
  localparam int EVENT_IE_BIT = 0;
  localparam logic [7:0] MODE_MASK = 8'h7f;

  //////////////////////////////////////////////////////////////////////
  // values after reset and fixed levels
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [15:0] COMPARE_RESET = 16'h0000;
  localparam logic [7:0] DUTY_RESET = 8'h00;
  localparam logic RUN_RESET = 1'b0;
  localparam logic WATCHDOG_RESET = 1'b0;
  localparam logic [7:0] LOW_BYTE_TOP = 8'hff;

endpackage : counter_array_pkg

// ---- counter_array_sync.sv ----
// two-stage synchroniser for the module pins.
// assumes the inputs are asynchronous to ref_clk.
`timescale 1ns/100ps
`default_nettype none

module counter_array_sync #(
  parameter int WIDTH = counter_array_pkg::NUM_MODULES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] rawIn,
  output logic [WIDTH-1:0] syncOut
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } state_type;

  state_type s;
  state_type next_s;

  // first stage feeds only the second stage
  always_comb begin
    next_s = s;
    next_s.first = rawIn;
    next_s.second = s.first;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign syncOut = s.second;

endmodule : counter_array_sync
`default_nettype wire
